// [core/rpc_cfg.svh]
/*
 reset pin control constants: timing counts and reset values.
 assumes a 200 MHz system clock.
*/
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define RPC_DRIVE_CYCLES   4'h6
`define RPC_SETTLE_CYCLES  4'h2
`define RPC_SYNC_STAGES    2
`define RPC_CNT_W          4

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RPC_PIN_IDLE       1'b1
`define RPC_HOLD_ON        1'b1

`endif

// [core/rpc_pkg.sv]
/*
 reset pin control package: state enum and the reset-output bundle.
 assumes rpc_cfg.svh is on the include path.
*/
package rpc_pkg;

   // -----------------------------------------------------------------
   // soft reset pin sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      RPC_ST_SENSE = 2'h0,
      RPC_ST_DRIVE = 2'h1,
      RPC_ST_RUN   = 2'h2
   } rpc_state_t;

   // -----------------------------------------------------------------
   // reset outputs to the rest of the chip
   // -----------------------------------------------------------------
   typedef struct packed {
      logic por_domain_rst;
      logic core_domain_rst;
      logic cpu_start;
   } rpc_rst_t;

endpackage

// [core/rpc_sync.sv]
/*
 rpc_sync: two-flop synchroniser for a group of pin levels.
 assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"

module rpc_sync #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // levels
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= {W{`RPC_PIN_IDLE}};
         sync_q <= {W{`RPC_PIN_IDLE}};
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule // rpc_sync
`default_nettype wire

// [core/rpc_top.sv]
/*
 rpc_top: hardware and software reset pin handling.
 assumes pins are already resolved to levels; open-drain wire modelled
 outside from soft_reset_io_n_o and soft_reset_io_n_oe.
*/
// How it works
// - low hardware pin holds full reset
// - hardware release gives full reset, then execution
// - full reset spares the clock keeper logic
// - low soft pin holds core domain reset
// - soft release resets cpu, registers, peripherals
// - soft reset spares por, clock, debug state
// - soft pin sensed low, device drives low
// - drive low six cycles, then sample again
// - repeat sample and drive until pin high
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"

module rpc_top #(
   parameter logic [`RPC_CNT_W-1:0] DRIVE_CYCLES = `RPC_DRIVE_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // hardware reset pin
   input  wire logic hw_reset_in_n,
   // soft reset pin, three signals
   input  wire logic soft_reset_io_n_i,
   output var  logic soft_reset_io_n_o,
   output var  logic soft_reset_io_n_oe,
   // resets to the chip
   output var  logic por_domain_rst,
   output var  logic core_domain_rst,
   output var  logic cpu_start,
   output var  logic clock_keeper_rst
);

   // -----------------------------------------------------------------
   // synchronisers
   // -----------------------------------------------------------------
   logic [1:0] pins_s;

   rpc_sync #(.W(2)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({hw_reset_in_n, soft_reset_io_n_i}),
      .sync_out (pins_s)
   );

   logic hw_n_s;
   logic sw_n_s;
   assign hw_n_s = pins_s[1];
   assign sw_n_s = pins_s[0];

   // -----------------------------------------------------------------
   // hardware reset
   // -----------------------------------------------------------------
   logic por_q;
   logic por_d;

   always_comb begin
      por_d = ~hw_n_s;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         por_q <= `RPC_HOLD_ON;
      end else begin
         por_q <= por_d;
      end
   end

   // -----------------------------------------------------------------
   // soft reset pin sequencer
   // -----------------------------------------------------------------
   rpc_pkg::rpc_state_t     st_q;
   rpc_pkg::rpc_state_t     st_d;
   logic [`RPC_CNT_W-1:0]   cnt_q;
   logic [`RPC_CNT_W-1:0]   cnt_d;
   logic                    oe_q;
   logic                    oe_d;
   rpc_pkg::rpc_rst_t       rst_q;
   rpc_pkg::rpc_rst_t       rst_d;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      oe_d  = 1'b0;
      if (por_q) begin
         // full reset restarts the sequencer from sensing
         st_d  = rpc_pkg::RPC_ST_SENSE;
         cnt_d = '0;
      end else begin
         case (st_q)
            rpc_pkg::RPC_ST_SENSE: begin
               if (cnt_q != '0) begin
                  // wait for the released pin to clear the synchroniser
                  cnt_d = cnt_q - 4'h1;
               end else if (!sw_n_s) begin
                  st_d  = rpc_pkg::RPC_ST_DRIVE;
                  cnt_d = DRIVE_CYCLES;
                  oe_d  = 1'b1;
               end else begin
                  st_d = rpc_pkg::RPC_ST_RUN;
               end
            end
            rpc_pkg::RPC_ST_DRIVE: begin
               if (cnt_q == 4'h1) begin
                  st_d  = rpc_pkg::RPC_ST_SENSE;
                  cnt_d = `RPC_SETTLE_CYCLES;
               end else begin
                  cnt_d = cnt_q - 4'h1;
                  oe_d  = 1'b1;
               end
            end
            rpc_pkg::RPC_ST_RUN: begin
               if (!sw_n_s) begin
                  st_d  = rpc_pkg::RPC_ST_DRIVE;
                  cnt_d = DRIVE_CYCLES;
                  oe_d  = 1'b1;
               end
            end
            default: begin
               st_d = rpc_pkg::RPC_ST_SENSE;
            end
         endcase
      end
      // outputs follow the next state
      rst_d.por_domain_rst  = por_q;
      rst_d.core_domain_rst = por_q |
                              (st_d != rpc_pkg::RPC_ST_RUN);
      rst_d.cpu_start       = (st_d == rpc_pkg::RPC_ST_RUN);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q  <= rpc_pkg::RPC_ST_SENSE;
         cnt_q <= '0;
         oe_q  <= 1'b0;
         rst_q <= '{por_domain_rst: 1'b1, core_domain_rst: 1'b1,
                    cpu_start: 1'b0};
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         oe_q  <= oe_d;
         rst_q <= rst_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // clock keeper domain is never reset by these pins
   logic ck_q;
   logic pin_lvl_q;
   always_ff @(posedge clk) begin
      ck_q      <= 1'b0;
      pin_lvl_q <= 1'b0;
   end

   assign soft_reset_io_n_o  = pin_lvl_q;
   assign soft_reset_io_n_oe = oe_q;
   assign por_domain_rst     = rst_q.por_domain_rst;
   assign core_domain_rst    = rst_q.core_domain_rst;
   assign cpu_start          = rst_q.cpu_start;
   assign clock_keeper_rst   = ck_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   logic [3:0] oe_run_q;
   always_ff @(posedge clk) begin
      if (sys_rst || !oe_q) begin
         oe_run_q <= '0;
      end else begin
         oe_run_q <= oe_run_q + 4'h1;
      end
   end

   AST_HW_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !hw_n_s |-> ##2 por_domain_rst && core_domain_rst)
      else $error("hardware pin low but chip not held");
   AST_HW_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(hw_n_s) && sw_n_s |-> ##[1:4] cpu_start)
      else $error("no start after hardware release");
   AST_CK_SPARED: assert property (@(posedge clk) disable iff (sys_rst)
      por_domain_rst |-> !clock_keeper_rst)
      else $error("clock keeper reset by full reset");
   AST_SW_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !sw_n_s |=> core_domain_rst)
      else $error("soft pin low but core running");
   AST_SW_NO_POR: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) && !$past(sys_rst, 2) &&
      hw_n_s && $past(hw_n_s) && $past(hw_n_s, 2) |-> !por_domain_rst)
      else $error("soft reset touched por domain");
   AST_DRIVE_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      !por_q && st_q == rpc_pkg::RPC_ST_RUN && !sw_n_s |=> oe_q)
      else $error("soft pin low not driven");
   AST_DRIVE_SIX: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(oe_q) |-> oe_q [*6] ##1 !oe_q)
      else $error("drive not six cycles");
   AST_DRIVE_MAX: assert property (@(posedge clk) disable iff (sys_rst)
      oe_run_q <= DRIVE_CYCLES)
      else $error("drive too long");
   AST_REPEAT: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(oe_q) ##2 (!sw_n_s && !por_q) |=> oe_q)
      else $error("no repeat while pin low");
   AST_SETTLE: assert property (@(posedge clk) disable iff (sys_rst)
      !por_q && st_q == rpc_pkg::RPC_ST_SENSE && cnt_q != '0 |=> !oe_q)
      else $error("pin driven while settling");
   AST_LEAVE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(cpu_start) |-> $past(sw_n_s))
      else $error("left soft reset without high sample");
   AST_DRIVE_VAL: assert property (@(posedge clk) disable iff (sys_rst)
      soft_reset_io_n_oe |-> !soft_reset_io_n_o)
      else $error("soft pin driven high");
   AST_RUN_OK: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_start |-> !core_domain_rst && !oe_q)
      else $error("running while core reset");

   COV_HW_CYCLE: cover property (@(posedge clk) $rose(cpu_start));
   COV_SW_PULSE: cover property (@(posedge clk) $rose(oe_q));
   COV_SW_REPEAT: cover property (@(posedge clk)
      $fell(oe_q) ##3 $rose(oe_q));
   COV_SW_LEAVE: cover property (@(posedge clk) $fell(core_domain_rst));

endmodule // rpc_top
`default_nettype wire

// [verif/rpc_board.sv]
/*
 rpc_board: board-level reset source facing the two reset pins.
 assumes both pins carry pull-ups; soft pin is a wired-and with the device.
*/
`timescale 1ns/1ps
`default_nettype none

module rpc_board (
   // board commands
   input  wire logic hold_hw,
   input  wire logic hold_soft,
   // device side of the soft pin
   input  wire logic dev_o,
   input  wire logic dev_oe,
   // resolved pin levels
   output wire logic hw_reset_in_n,
   output wire logic soft_reset_io_n
);
   // released pins float up to the pull-up level
   assign hw_reset_in_n   = !hold_hw;
   assign soft_reset_io_n = !(hold_soft || (dev_oe && !dev_o));
endmodule // rpc_board

`default_nettype wire

// [verif/tb.sv]
/*
 tb: self-checking bench for rpc_top with the board reset model.
 assumes rpc_top, rpc_board and rpc_cfg.svh are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic clk, sys_rst, hold_hw, hold_soft;
   logic o, oe, por, core, start, ck;
   wire logic hw_n, soft_n;
   int fails, n_checks;

   rpc_top dut (.clk(clk), .sys_rst(sys_rst), .hw_reset_in_n(hw_n),
      .soft_reset_io_n_i(soft_n), .soft_reset_io_n_o(o),
      .soft_reset_io_n_oe(oe), .por_domain_rst(por),
      .core_domain_rst(core), .cpu_start(start), .clock_keeper_rst(ck));
   rpc_board board (.hold_hw(hold_hw), .hold_soft(hold_soft), .dev_o(o),
      .dev_oe(oe), .hw_reset_in_n(hw_n), .soft_reset_io_n(soft_n));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_run();
      for (int i = 0; i < 40 && start !== 1'b1; i++) tick(1);
      chk("cpu_start", {7'h0, start}, 8'h01);
      chk("core_rst", {7'h0, core}, 8'h00);
      chk("oe_idle", {7'h0, oe}, 8'h00);
   endtask
   task automatic end_of_test();
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_hw();
      @(posedge clk) hold_hw <= 1'b1;
      tick(2);
      chk("por_lag", {7'h0, por}, 8'h00);
      tick(2);
      chk("por_on", {7'h0, por}, 8'h01);
      tick(20);
      chk("por_hold", {7'h0, por}, 8'h01);
      chk("start_hold", {7'h0, start}, 8'h00);
      chk("ck_hold", {7'h0, ck}, 8'h00);
      @(posedge clk) hold_hw <= 1'b0;
      wait_run();
      chk("por_off", {7'h0, por}, 8'h00);
      chk("ck_after", {7'h0, ck}, 8'h00);
   endtask

   task automatic t_soft_short();
      int n;
      @(posedge clk) hold_soft <= 1'b1;
      for (int i = 0; i < 10 && oe !== 1'b1; i++) tick(1);
      chk("oe_rise", {7'h0, oe}, 8'h01);
      chk("o_low", {7'h0, o}, 8'h00);
      chk("core_soft", {7'h0, core}, 8'h01);
      chk("start_soft", {7'h0, start}, 8'h00);
      chk("por_soft", {7'h0, por}, 8'h00);
      n = 1;
      @(posedge clk) hold_soft <= 1'b0;
      #1;
      while (oe === 1'b1 && n < 20) begin
         n++;
         tick(1);
      end
      chk("drive_len", n[7:0], 8'h06);
      wait_run();
      chk("por_after", {7'h0, por}, 8'h00);
   endtask

   task automatic t_soft_long();
      int rises, bad;
      logic prev;
      rises = 0;
      bad = 0;
      prev = 1'b0;
      @(posedge clk) hold_soft <= 1'b1;
      repeat (40) begin
         tick(1);
         if (oe === 1'b1 && prev === 1'b0) rises++;
         prev = oe;
         if (por !== 1'b0) bad++;
      end
      chk("repeats", {7'h0, rises >= 4}, 8'h01);
      chk("core_long", {7'h0, core}, 8'h01);
      chk("por_long", bad[7:0], 8'h00);
      @(posedge clk) hold_soft <= 1'b0;
      wait_run();
   endtask

   // -----------------------------------------------------------------
   // clock, watchdog, main sequence
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      end_of_test();
   end

   initial begin
      fails = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      hold_hw = 1'b0;
      hold_soft = 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      tick(1);
      chk("ck_reset", {7'h0, ck}, 8'h00);
      wait_run();
      t_hw();
      t_soft_short();
      t_soft_long();
      t_hw();
      end_of_test();
   end
endmodule // tb

`default_nettype wire
